// ### rpsf_far_model.sv
// Far-side model of one receive port: the remote serializer's events and link levels.
`timescale 1ns/1ns
module rpsf_far_model
  import rpsf_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] ev,
  input wire logic [5:0] lv,
  output rpsf_port_in_s p
);
  // Events leave as one-cycle pulses and levels leave on the same edge, as the link recovers them.
  // An encoding error is only reported while lock holds, so the host keeps the error limit above one.
  // Event bit 7 stands for the host clearing the parity counters.
  always @(posedge clk) begin
    p <= {ev[0], ev[1], ev[2], ev[3], ev[4] & lv[0], ev[5], ev[6],
          lv[0], lv[1], lv[2], lv[3], lv[4], lv[5], ev[7]};
  end
endmodule // rpsf_far_model

// ### rpsf_pkg.sv
// Package for the receive-port status flag block: offsets, bit positions, carriers.
package rpsf_pkg;

  // Register offsets; the second status register follows the first.
  localparam logic [7:0] RPSF_OFF_STS_ONE = 8'h4D;
  localparam logic [7:0] RPSF_OFF_STS_TWO = 8'h4E;

  // Bit positions in the first status register.
  localparam int RPSF_S1_PORT = 6;
  localparam int RPSF_S1_CRC = 5;
  localparam int RPSF_S1_LCHG = 4;
  localparam int RPSF_S1_SEQ = 3;
  localparam int RPSF_S1_PAR = 2;
  localparam int RPSF_S1_PASS = 1;
  localparam int RPSF_S1_LOCK = 0;

  // Bit positions in the second status register.
  localparam int RPSF_S2_WUNST = 7;
  localparam int RPSF_S2_WCHG = 6;
  localparam int RPSF_S2_ENC = 5;
  localparam int RPSF_S2_BUF = 4;
  localparam int RPSF_S2_CAM = 3;
  localparam int RPSF_S2_FREQ = 2;
  localparam int RPSF_S2_NOCLK = 1;
  localparam int RPSF_S2_RCHG = 0;

  // Reset values of the registers.
  localparam logic [7:0] RPSF_RST_STS = 8'h00;

  // Number of receive ports.
  localparam int RPSF_NPORTS = 2;

  // Event pulses and live levels of one receive port.
  typedef struct packed {
    logic ctrl_channel_crc_err;
    logic ctrl_channel_seq_err;
    logic row_width_unstable;
    logic row_width_change;
    logic link_encoding_err;
    logic fifo_overflow;
    logic row_count_change;
    logic receiver_locked;
    logic port_pass;
    logic camera_input_err;
    logic rate_measure_settled;
    logic link_clock_absent;
    logic parity_over_limit;
    logic parity_counter_clear;
  } rpsf_port_in_s;

  // Register read access.
  typedef struct packed {
    logic rd;
    logic [7:0] addr;
  } rpsf_rd_req_s;

endpackage

// ### rpsf_status_flags.sv
// Receive-port status flag registers for both ports with paged readback.
`timescale 1ns/1ns

module rpsf_status_flags
  import rpsf_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic read_port_sel,
  input wire rpsf_port_in_s [RPSF_NPORTS-1:0] port_in,
  input wire rpsf_rd_req_s rd_req,
  output logic [7:0] rd_data,
  output logic rd_hit
);

  // Reset release through two flip-flops.
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Set wins over clear so an event in the read cycle survives.
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // Read decode; the page select steers which port is cleared as well as read.
  wire rd_one = rd_req.rd && (rd_req.addr == RPSF_OFF_STS_ONE);
  wire rd_two = rd_req.rd && (rd_req.addr == RPSF_OFF_STS_TWO);

  logic [RPSF_NPORTS-1:0] crc_q, seq_q, lchg_q, lock_q, par_q;
  logic [RPSF_NPORTS-1:0] wunst_q, wchg_q, enc_q, buf_q, rchg_q;
  logic [7:0] sts_one [RPSF_NPORTS];
  logic [7:0] sts_two [RPSF_NPORTS];

  // Per-port page match and clear strobes, kept as nets so each bit has one driver.
  wire [RPSF_NPORTS-1:0] sel;
  wire [RPSF_NPORTS-1:0] clr_one;
  wire [RPSF_NPORTS-1:0] clr_two;
  wire [RPSF_NPORTS-1:0] lock_edge;

  for (genvar p = 0; p < RPSF_NPORTS; p++) begin : g_port
    // A read clears only the port that the page select points at.
    assign sel[p] = (read_port_sel == 1'(p));
    assign clr_one[p] = rd_one && sel[p];
    assign clr_two[p] = rd_two && sel[p];
    // Any difference between the pin and its registered copy is a lock edge.
    assign lock_edge[p] = port_in[p].receiver_locked ^ lock_q[p];

    // Register images; pass, camera, rate and clock-absent levels are read straight, lock and parity registered, bit 7 of the first reads zero.
    always_comb begin
      sts_one[p] = RPSF_RST_STS;
      sts_one[p][RPSF_S1_PORT] = read_port_sel;
      sts_one[p][RPSF_S1_CRC] = crc_q[p];
      sts_one[p][RPSF_S1_LCHG] = lchg_q[p];
      sts_one[p][RPSF_S1_SEQ] = seq_q[p];
      sts_one[p][RPSF_S1_PAR] = par_q[p];
      sts_one[p][RPSF_S1_PASS] = port_in[p].port_pass;
      sts_one[p][RPSF_S1_LOCK] = lock_q[p];
      sts_two[p] = RPSF_RST_STS;
      sts_two[p][RPSF_S2_WUNST] = wunst_q[p];
      sts_two[p][RPSF_S2_WCHG] = wchg_q[p];
      sts_two[p][RPSF_S2_ENC] = enc_q[p];
      sts_two[p][RPSF_S2_BUF] = buf_q[p];
      sts_two[p][RPSF_S2_CAM] = port_in[p].camera_input_err;
      sts_two[p][RPSF_S2_FREQ] = port_in[p].rate_measure_settled;
      sts_two[p][RPSF_S2_NOCLK] = port_in[p].link_clock_absent;
      sts_two[p][RPSF_S2_RCHG] = rchg_q[p];
    end
  end

  // Status-one event flags; set wins over the read clear so no event is lost.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      crc_q <= '0;
      seq_q <= '0;
      lchg_q <= '0;
    end else begin
      for (int i = 0; i < RPSF_NPORTS; i++) begin
        crc_q[i] <= sticky(crc_q[i], port_in[i].ctrl_channel_crc_err, clr_one[i]);
        seq_q[i] <= sticky(seq_q[i], port_in[i].ctrl_channel_seq_err, clr_one[i]);
        lchg_q[i] <= sticky(lchg_q[i], lock_edge[i], clr_one[i]);
      end
    end
  end

  // Registered levels; reads never touch them.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lock_q <= '0;
      par_q <= '0;
    end else begin
      for (int i = 0; i < RPSF_NPORTS; i++) begin
        lock_q[i] <= port_in[i].receiver_locked;
        // The counter clear forces the level low for one cycle, the comparator decides after that.
        par_q[i] <= port_in[i].parity_over_limit & ~port_in[i].parity_counter_clear;
      end
    end
  end

  // Status-two event flags, cleared by a read of their own register.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wunst_q <= '0;
      wchg_q <= '0;
      enc_q <= '0;
      buf_q <= '0;
      rchg_q <= '0;
    end else begin
      for (int i = 0; i < RPSF_NPORTS; i++) begin
        wunst_q[i] <= sticky(wunst_q[i], port_in[i].row_width_unstable, clr_two[i]);
        wchg_q[i] <= sticky(wchg_q[i], port_in[i].row_width_change, clr_two[i]);
        enc_q[i] <= sticky(enc_q[i], port_in[i].link_encoding_err, clr_two[i]);
        buf_q[i] <= sticky(buf_q[i], port_in[i].fifo_overflow, clr_two[i]);
        rchg_q[i] <= sticky(rchg_q[i], port_in[i].row_count_change, clr_two[i]);
      end
    end
  end

  // Readback mux by page select; data registered, pre-clear value returned.
  wire [7:0] rd_mux = rd_one ? sts_one[read_port_sel] : (rd_two ? sts_two[read_port_sel] : 8'h00);
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_data <= RPSF_RST_STS;
      rd_hit <= 1'b0;
    end else begin
      rd_data <= rd_mux;
      rd_hit <= rd_one | rd_two;
    end
  end

  // Checks next to the flag logic.
  chk_crc_read_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_one && read_port_sel == 1'b0 && !port_in[0].ctrl_channel_crc_err) |=> !crc_q[0])
    else $error("CRC flag survived a read.");
  chk_crc_set_wins: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[0].ctrl_channel_crc_err |=> crc_q[0])
    else $error("CRC event lost.");
  chk_lock_change_flag: assert property (@(posedge clk) disable iff (!rst_n_q)
    (port_in[1].receiver_locked != $past(port_in[1].receiver_locked)) |=> lchg_q[1])
    else $error("Lock change not flagged.");
  chk_seq_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
    (seq_q[0] && !(rd_one && !read_port_sel)) |=> seq_q[0])
    else $error("Sequence flag dropped without read.");
  chk_parity_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[0].parity_counter_clear |=> !par_q[0])
    else $error("Parity flag not cleared with counters.");
  chk_parity_level: assert property (@(posedge clk) disable iff (!rst_n_q)
    (port_in[1].parity_over_limit && !port_in[1].parity_counter_clear) |=> par_q[1])
    else $error("Parity flag missing.");
  chk_port_number: assert property (@(posedge clk) disable iff (!rst_n_q)
    rd_one |=> rd_hit && rd_data[RPSF_S1_PORT] == $past(read_port_sel))
    else $error("Port number wrong.");
  chk_encode_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
    (port_in[1].link_encoding_err ##1 !rd_two [*2]) |-> enc_q[1])
    else $error("Encoding flag lost.");
  chk_noclk_read: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_two && read_port_sel && port_in[1].link_clock_absent) |=> rd_data[RPSF_S2_NOCLK])
    else $error("Clock absent not shown.");
  chk_row_count: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_two && !read_port_sel && !port_in[0].row_count_change) |=> !rchg_q[0])
    else $error("Row count flag survived a read.");

  // The page bit reads back as the select that was in force at the read.
  chk_port_bit_one: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_one && read_port_sel) |=> rd_data[RPSF_S1_PORT])
    else $error("Port bit low for port one.");
  chk_port_bit_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_one && !read_port_sel) |=> !rd_data[RPSF_S1_PORT])
    else $error("Port bit high for port zero.");
  // The unused top bit of the first register always reads zero.
  chk_spare_bit: assert property (@(posedge clk) disable iff (!rst_n_q)
    rd_one |=> !rd_data[7])
    else $error("Spare bit not zero.");
  // Port one CRC flag clears on its own read and holds otherwise.
  chk_crc_port_one: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_one && read_port_sel && !port_in[1].ctrl_channel_crc_err) |=> !crc_q[1])
    else $error("Port one CRC flag survived a read.");
  chk_crc_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
    (crc_q[1] && !clr_one[1]) |=> crc_q[1])
    else $error("CRC flag dropped without read.");
  // A read of the other page must leave this port's flags alone.
  chk_clear_other_port: assert property (@(posedge clk) disable iff (!rst_n_q)
    (crc_q[1] && rd_one && !read_port_sel) |=> crc_q[1])
    else $error("Read cleared the wrong port.");
  // Lock change flag sets from the edge and clears on read.
  chk_lock_change_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    (port_in[0].receiver_locked != lock_q[0]) |=> lchg_q[0])
    else $error("Port zero lock change not flagged.");
  chk_lock_change_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    (clr_one[0] && !lock_edge[0]) |=> !lchg_q[0])
    else $error("Lock change flag survived a read.");
  // Sequence flag clears on read and keeps an event that meets the read.
  chk_seq_read_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_one && read_port_sel && !port_in[1].ctrl_channel_seq_err) |=> !seq_q[1])
    else $error("Sequence flag survived a read.");
  chk_seq_set_wins: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[1].ctrl_channel_seq_err |=> seq_q[1])
    else $error("Sequence event lost.");
  // Parity flag follows the comparator and ignores reads.
  chk_parity_low: assert property (@(posedge clk) disable iff (!rst_n_q)
    !port_in[0].parity_over_limit |=> !par_q[0])
    else $error("Parity flag high below threshold.");
  chk_parity_read_kept: assert property (@(posedge clk) disable iff (!rst_n_q)
    (clr_one[0] && port_in[0].parity_over_limit && !port_in[0].parity_counter_clear) |=> par_q[0])
    else $error("Parity flag cleared by a read.");
  chk_parity_clear_one: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[1].parity_counter_clear |=> !par_q[1])
    else $error("Port one parity flag not cleared with counters.");
  // Pass state is live on both pages.
  chk_pass_live_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_one && !read_port_sel) |=> rd_data[RPSF_S1_PASS] == $past(port_in[0].port_pass))
    else $error("Pass bit wrong on port zero.");
  chk_pass_live_one: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_one && read_port_sel) |=> rd_data[RPSF_S1_PASS] == $past(port_in[1].port_pass))
    else $error("Pass bit wrong on port one.");
  // Lock bit is the pin registered once.
  chk_lock_bit: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[0].receiver_locked |=> lock_q[0])
    else $error("Lock bit missing.");
  // Row width unstable flag sets and stays until its read.
  chk_unstable_set: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[1].row_width_unstable |=> wunst_q[1])
    else $error("Row width unstable not flagged.");
  chk_unstable_sticky: assert property (@(posedge clk) disable iff (!rst_n_q)
    (wunst_q[0] && !clr_two[0]) |=> wunst_q[0])
    else $error("Row width unstable dropped without read.");
  // Row width change flag sets, keeps a colliding event and clears on read.
  chk_width_change_set: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[0].row_width_change |=> wchg_q[0])
    else $error("Row width change lost.");
  chk_width_change_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    (clr_two[1] && !port_in[1].row_width_change) |=> !wchg_q[1])
    else $error("Row width change survived a read.");
  // Encoding error flag sets and clears on read.
  chk_encode_set: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[0].link_encoding_err |=> enc_q[0])
    else $error("Encoding error not flagged.");
  chk_encode_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    (clr_two[0] && !port_in[0].link_encoding_err) |=> !enc_q[0])
    else $error("Encoding flag survived a read.");
  // Buffer overflow flag sets and clears on read.
  chk_overflow_set: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[1].fifo_overflow |=> buf_q[1])
    else $error("Overflow not flagged.");
  chk_overflow_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    (clr_two[1] && !port_in[1].fifo_overflow) |=> !buf_q[1])
    else $error("Overflow flag survived a read.");
  // Live levels of the second register.
  chk_camera_live: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_two && !read_port_sel) |=> rd_data[RPSF_S2_CAM] == $past(port_in[0].camera_input_err))
    else $error("Camera error bit wrong.");
  chk_settled_live: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_two && read_port_sel) |=> rd_data[RPSF_S2_FREQ] == $past(port_in[1].rate_measure_settled))
    else $error("Rate settled bit wrong.");
  chk_clock_absent_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_two && !read_port_sel) |=> rd_data[RPSF_S2_NOCLK] == $past(port_in[0].link_clock_absent))
    else $error("Clock absent bit wrong on port zero.");
  // Row count flag sets and holds until its read.
  chk_row_count_set: assert property (@(posedge clk) disable iff (!rst_n_q)
    port_in[1].row_count_change |=> rchg_q[1])
    else $error("Row count change not flagged.");
  chk_row_count_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rchg_q[1] && !clr_two[1]) |=> rchg_q[1])
    else $error("Row count flag dropped without read.");
  // Other addresses are refused and the hit lasts one cycle.
  chk_read_refused: assert property (@(posedge clk) disable iff (!rst_n_q)
    (rd_req.rd && !rd_one && !rd_two) |=> !rd_hit && rd_data == 8'h00)
    else $error("Read of a foreign address answered.");
  chk_hit_one_cycle: assert property (@(posedge clk) disable iff (!rst_n_q)
    !(rd_one || rd_two) |=> !rd_hit)
    else $error("Hit without a read.");

  cov_lock_change_read: cover property (@(posedge clk) disable iff (!rst_n_q) lchg_q[0] ##1 rd_one);
  cov_port_one_read: cover property (@(posedge clk) disable iff (!rst_n_q) rd_two && read_port_sel && buf_q[1]);
  cov_set_during_clear: cover property (@(posedge clk) disable iff (!rst_n_q)
    rd_one && !read_port_sel && port_in[0].ctrl_channel_crc_err);
  cov_parity_clear: cover property (@(posedge clk) disable iff (!rst_n_q)
    port_in[0].parity_counter_clear && port_in[0].parity_over_limit);

endmodule // rpsf_status_flags

// ### rpsf_status_flags_tb.sv
// Self-checking bench for the receive-port status flag registers.
`timescale 1ns/1ns
module rpsf_status_flags_tb;
  import rpsf_pkg::*;
  logic clk, arst_n, read_port_sel, rd_hit, pend, par_clr;
  rpsf_rd_req_s rd_req;
  logic [7:0] rd_data;
  logic [7:0] ev [2];
  logic [5:0] lv [2];
  logic [7:0] s1c [2];
  logic [7:0] s2c [2];
  wire rpsf_port_in_s [RPSF_NPORTS-1:0] port_in;
  logic [8:0] expq [$];
  logic [8:0] exp_v;
  int error_cnt, check_count;

  rpsf_status_flags i_dut (.clk(clk), .arst_n(arst_n), .read_port_sel(read_port_sel), .port_in(port_in),
    .rd_req(rd_req), .rd_data(rd_data), .rd_hit(rd_hit));
  for (genvar g = 0; g < 2; g++) begin : g_far
    rpsf_far_model i_far (.clk(clk), .ev(ev[g]), .lv(lv[g]), .p(port_in[g]));
  end

  // Free-running clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // The answer lands one edge after the read is taken, so each hit is matched to the oldest note.
  always @(posedge clk) begin
    if (pend) begin
      exp_v = expq.pop_front();
      check_count++;
      if ({rd_hit, rd_data} !== exp_v) begin
        error_cnt++;
        $display("mismatch rd_hit_data expected %h seen %h", exp_v, {rd_hit, rd_data});
      end
    end
    pend = rd_req.rd;
  end

  // Model of the sticky flags; the caller applies the set side before the event fires or, for a read collision, after it lands.
  task automatic note(input logic p, input logic [7:0] e, input logic [5:0] l);
    if (l[0] !== lv[p][0]) s1c[p] |= 8'h10;
    s1c[p] |= {2'h0, e[0], 1'b0, e[1], 3'h0};
    s2c[p] |= {e[2], e[3], e[4] & l[0], e[5], 3'h0, e[6]};
  endtask

  task automatic fire(input logic p, input logic [7:0] e, input logic [5:0] l);
    ev[p] <= e;
    lv[p] <= l;
    @(posedge clk);
    ev[p] <= 8'h00;
  endtask

  // Reads are held high back to back; the caller drops the strobe when the burst is over.
  task automatic rd(input logic p, input logic [7:0] a);
    logic [8:0] e;
    e = 9'h000;
    if (a == RPSF_OFF_STS_ONE) e = {1'b1, s1c[p] | {1'b0, p, 3'h0, lv[p][5] & ~par_clr, lv[p][1], lv[p][0]}};
    if (a == RPSF_OFF_STS_TWO) e = {1'b1, s2c[p] | {4'h0, lv[p][2], lv[p][3], lv[p][4], 1'b0}};
    expq.push_back(e);
    if (a == RPSF_OFF_STS_ONE) s1c[p] = 8'h00;
    if (a == RPSF_OFF_STS_TWO) s2c[p] = 8'h00;
    read_port_sel <= p;
    rd_req <= {1'b1, a};
    @(posedge clk);
  endtask

  task automatic summarize();
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    summarize();
  end

  initial begin
    logic p;
    logic [7:0] e;
    logic [5:0] l;
    logic [7:0] a;
    arst_n = 1'b0;
    read_port_sel = 1'b0;
    rd_req = '0;
    par_clr = 1'b0;
    ev = '{8'h00, 8'h00};
    lv = '{6'h00, 6'h00};
    s1c = '{8'h00, 8'h00};
    s2c = '{8'h00, 8'h00};
    pend = 1'b0;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(90006));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      rd(i[0], RPSF_OFF_STS_ONE);
      rd(i[0], RPSF_OFF_STS_TWO);
    end
    for (int i = 0; i < 40; i++) begin
      p = $urandom;
      e = $urandom;
      l = $urandom;
      a = $urandom;
      if (a == RPSF_OFF_STS_ONE || a == RPSF_OFF_STS_TWO) a = 8'h00;
      note(p, e, l);
      rd_req <= '0;
      fire(p, e, l);
      repeat (4) @(posedge clk);
      p = $urandom;
      rd(p, RPSF_OFF_STS_ONE);
      rd(p, RPSF_OFF_STS_TWO);
      rd(p, a);
      rd(p, RPSF_OFF_STS_ONE);
      rd(p, RPSF_OFF_STS_TWO);
      rd_req <= '0;
      fire(p, 8'hFF, lv[p]);
      rd(p, RPSF_OFF_STS_ONE);
      note(p, 8'hFF, lv[p]);
      par_clr = 1'b1;
      rd(p, RPSF_OFF_STS_ONE);
      par_clr = 1'b0;
    end
    rd_req <= '0;
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule // rpsf_status_flags_tb
